// ===== inc/cscl_pkg.sv
// Function
// - count call depth only when enable bit 7 set and depth field not all ones
// - cleared enable suspends counting; next call sets enable again
// - depth field all ones disables counting regardless of enable bit
// - depth field is leading-ones prefix, first zero, then count bits
// - call increments count, return decrements count while counting active
// - counter width shrinks per leading one, six bits to zero; overflow traps
// - carry 31, overflow 30, sticky 29, advance 28, sticky advance 27
// - carry-using adds write carry to bit 31; carry-in is old bit 31
// - status bits 23:16 read zero after reset and after a write (write mask clears 26:14)
// - lowest user level denies peripherals and interrupt enable changes
// - second user level allows common peripherals and interrupt disable
// - supervisor allows system registers, all peripherals, interrupt disable
// - interrupt dispatch is done in hardware without scheduling software
// - hardware saves task context in the link register only; status word is not saved
// - link register holds prior priority 31:24 and prior enable 23
// - bit 22 tags lower or upper context; mismatch on restore traps
// - save-area pointer is segment 19:16 and offset 15:0
// - privilege field 11:10: 00 user0, 01 user1, 10 supervisor
// - user0 access to peripheral-space region is blocked and traps
`default_nettype none
package cscl_pkg;
  localparam logic [15:0] link_offset_addr = 16'hfe00;
  localparam logic [15:0] status_word_addr = 16'hfe04;
  localparam int cde_pos = 7;
  localparam int carry_pos = 31;
  localparam int ovf_pos = 30;
  localparam int sovf_pos = 29;
  localparam int aovf_pos = 28;
  localparam int saovf_pos = 27;
  localparam int priv_lsb = 10;
  localparam int kind_pos = 22;
  localparam int pie_pos = 23;
  localparam logic [31:0] status_wmask = 32'hf800_3fff;
  localparam logic [31:0] link_wmask = 32'hffcf_ffff;
  localparam logic [31:0] status_reset = 32'h0000_0b80;
  localparam logic [31:0] link_reset = 32'h0000_0000;
  localparam logic [1:0] priv_user0 = 2'h0;
  localparam logic [1:0] priv_user1 = 2'h1;
  localparam logic [1:0] priv_super = 2'h2;
endpackage
`default_nettype wire

// ===== verilog/cscl_depth.sv
`default_nettype none
// combinational call-depth step; pure logic so it can be reused per event
module cscl_depth (
  input wire logic [6:0] field,
  input wire logic enable,
  input wire logic call_op,
  input wire logic ret_op,
  output logic [6:0] next_field,
  output logic next_enable,
  output logic overflow
);
  logic [6:0] cmask;
  logic active;
  always_comb
  begin
    // find width: count leading ones
    cmask = 7'h3f;
    if (field[6] == 1'b0) cmask = 7'h3f;
    else if (field[5] == 1'b0) cmask = 7'h1f;
    else if (field[4] == 1'b0) cmask = 7'h0f;
    else if (field[3] == 1'b0) cmask = 7'h07;
    else if (field[2] == 1'b0) cmask = 7'h03;
    else if (field[1] == 1'b0) cmask = 7'h01;
    else cmask = 7'h00;
    active = enable && (field != 7'h7f);
    next_field = field;
    next_enable = enable;
    overflow = 1'b0;
    if (active && call_op)
    begin
      // overflow when count portion is already full
      overflow = ((field & cmask) == cmask);
      next_field = (field & ~cmask) | ((field + 7'h01) & cmask);
    end
    else if (active && ret_op)
      next_field = (field & ~cmask) | ((field - 7'h01) & cmask);
    if (call_op && !enable)
      next_enable = 1'b1;
  end
endmodule
`default_nettype wire

// ===== verilog/cscl_priv.sv
`default_nettype none
// privilege checks from the two-bit level field
module cscl_priv (
  input wire logic [1:0] level,
  input wire logic periph_req,
  input wire logic sysreg_req,
  input wire logic irq_disable_req,
  input wire logic irq_enable_req,
  output logic periph_ok,
  output logic sysreg_ok,
  output logic irq_change_ok,
  output logic prot_fault
);
  always_comb
  begin
    periph_ok = 1'b0;
    sysreg_ok = 1'b0;
    irq_change_ok = 1'b0;
    if (level == cscl_pkg::priv_user1)
    begin
      periph_ok = 1'b1;
      irq_change_ok = irq_disable_req && !irq_enable_req;
    end
    else if (level == cscl_pkg::priv_super)
    begin
      periph_ok = 1'b1;
      sysreg_ok = 1'b1;
      irq_change_ok = 1'b1;
    end
    // user0 and reserved code: nothing permitted
    prot_fault = (periph_req && !periph_ok)
      || (sysreg_req && !sysreg_ok)
      || ((irq_disable_req || irq_enable_req) && !irq_change_ok);
  end
endmodule
`default_nettype wire

// ===== verilog/cscl_core_state.sv
`default_nettype none
module cscl_core_state (
  input wire logic clk,
  input wire logic rst_b,
  // core register move port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_err,
  // execution events
  input wire logic call_op,
  input wire logic ret_op,
  input wire logic carry_wr,
  input wire logic carry_out,
  input wire logic [4:0] flag_wr,
  input wire logic [4:0] flag_val,
  // access checks
  input wire logic periph_req,
  input wire logic sysreg_req,
  input wire logic irq_disable_req,
  input wire logic irq_enable_req,
  // interrupt entry and context restore
  input wire logic irq_take,
  input wire logic [7:0] cur_priority,
  input wire logic cur_irq_enable,
  input wire logic [19:0] save_ptr,
  input wire logic save_kind,
  input wire logic restore_op,
  input wire logic restore_expect,
  output logic carry_in,
  output logic [1:0] priv_level,
  output logic access_ok,
  output logic depth_trap,
  output logic prot_trap,
  output logic context_trap,
  output logic irq_dispatch,
  output logic [19:0] prev_ptr,
  output logic [7:0] prev_priority,
  output logic prev_irq_enable
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] link;
    logic [31:0] rdata;
    logic err;
    logic ok;
    logic dtrap;
    logic ptrap;
    logic ctrap;
    logic disp;
  } cscl_state_s;

  cscl_state_s q;
  cscl_state_s next_q;

  logic [6:0] d_field;
  logic d_enable;
  logic d_ovf;
  logic p_periph;
  logic p_sys;
  logic p_irq;
  logic p_fault;

  // ==========================================================
  // helpers
  cscl_depth u_depth (
    .field(q.status[6:0]),
    .enable(q.status[cscl_pkg::cde_pos]),
    .call_op(call_op),
    .ret_op(ret_op),
    .next_field(d_field),
    .next_enable(d_enable),
    .overflow(d_ovf)
  );

  cscl_priv u_priv (
    .level(q.status[cscl_pkg::priv_lsb +: 2]),
    .periph_req(periph_req),
    .sysreg_req(sysreg_req),
    .irq_disable_req(irq_disable_req),
    .irq_enable_req(irq_enable_req),
    .periph_ok(p_periph),
    .sysreg_ok(p_sys),
    .irq_change_ok(p_irq),
    .prot_fault(p_fault)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    next_q = q;
    next_q.err = 1'b0;
    next_q.dtrap = 1'b0;
    next_q.ptrap = 1'b0;
    next_q.ctrap = 1'b0;
    next_q.disp = 1'b0;
    next_q.rdata = 32'h0000_0000;
    // moves from core registers; status bits 26:14 and link bits 21:20 never stored so read zero
    if (reg_rd)
    begin
      if (reg_addr == cscl_pkg::link_offset_addr)
        next_q.rdata = q.link & cscl_pkg::link_wmask;
      else if (reg_addr == cscl_pkg::status_word_addr)
        next_q.rdata = q.status;
      else
        next_q.err = 1'b1;
    end
    // execution side effects
    next_q.status[6:0] = d_field;
    next_q.status[cscl_pkg::cde_pos] = d_enable;
    next_q.dtrap = d_ovf;
    if (carry_wr)
      next_q.status[cscl_pkg::carry_pos] = carry_out;
    for (int i = 0; i < 5; i++)
    begin
      if (flag_wr[i])
        next_q.status[cscl_pkg::saovf_pos + i] = flag_val[i];
    end
    next_q.ok = (periph_req || sysreg_req || irq_disable_req
      || irq_enable_req) && !p_fault;
    next_q.ptrap = p_fault;
    // hardware interrupt entry saves link state
    if (irq_take)
    begin
      next_q.disp = 1'b1;
      next_q.link = {cur_priority, cur_irq_enable, save_kind, 2'h0,
        save_ptr};
    end
    if (restore_op && restore_expect != q.link[cscl_pkg::kind_pos])
      next_q.ctrap = 1'b1;
    // software write takes priority over side effects; reserved masked
    if (reg_wr)
    begin
      if (reg_addr == cscl_pkg::link_offset_addr)
        next_q.link = reg_wdata & cscl_pkg::link_wmask;
      else if (reg_addr == cscl_pkg::status_word_addr)
        next_q.status = reg_wdata & cscl_pkg::status_wmask;
      else
        next_q.err = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.status <= cscl_pkg::status_reset;
      q.link <= cscl_pkg::link_reset;
    end
    else
      q <= next_q;
  end

  assign reg_rdata = q.rdata;
  assign reg_err = q.err;
  assign carry_in = q.status[cscl_pkg::carry_pos];
  assign priv_level = q.status[cscl_pkg::priv_lsb +: 2];
  assign access_ok = q.ok;
  assign depth_trap = q.dtrap;
  assign prot_trap = q.ptrap;
  assign context_trap = q.ctrap;
  assign irq_dispatch = q.disp;
  assign prev_ptr = q.link[19:0];
  assign prev_priority = q.link[31:24];
  assign prev_irq_enable = q.link[cscl_pkg::pie_pos];
endmodule
`default_nettype wire

// ===== verif/cscl_asserts.sv
`default_nettype none
module cscl_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic carry_wr,
  input wire logic carry_out,
  input wire logic carry_in,
  input wire logic periph_req,
  input wire logic sysreg_req,
  input wire logic [1:0] priv_level,
  input wire logic access_ok,
  input wire logic prot_trap,
  input wire logic irq_take,
  input wire logic [7:0] cur_priority,
  input wire logic [19:0] save_ptr,
  input wire logic [7:0] prev_priority,
  input wire logic [19:0] prev_ptr,
  input wire logic irq_dispatch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ====================
  // checks
  // register writes win over same-cycle events, so those are left out
  property p_disp; irq_take && !reg_wr |=> irq_dispatch; endproperty
  a_disp: assert property (p_disp) else $error("no dispatch");
  property p_link; irq_take && !reg_wr |=>
    {prev_priority, prev_ptr} == $past({cur_priority, save_ptr}); endproperty
  a_link: assert property (p_link) else $error("link load");
  property p_u0; priv_level == cscl_pkg::priv_user0 && periph_req |=>
    !access_ok; endproperty
  a_u0: assert property (p_u0) else $error("user0 access");
  property p_pse; priv_level == cscl_pkg::priv_user0 && periph_req |=>
    prot_trap; endproperty
  a_pse: assert property (p_pse) else $error("no prot trap");
  property p_sup; priv_level == cscl_pkg::priv_super && sysreg_req |=>
    access_ok; endproperty
  a_sup: assert property (p_sup) else $error("super denied");
  property p_u1; priv_level == cscl_pkg::priv_user1 && sysreg_req |=>
    !access_ok; endproperty
  a_u1: assert property (p_u1) else $error("user1 sysreg");
  property p_cy; carry_wr && !reg_wr |=> carry_in == $past(carry_out);
  endproperty
  a_cy: assert property (p_cy) else $error("carry bit");
  property p_res; reg_rd && reg_addr == cscl_pkg::link_offset_addr |=>
    reg_rdata[21:20] == 2'h0; endproperty
  a_res: assert property (p_res) else $error("link reserved");
endmodule
bind cscl_core_state cscl_asserts cscl_asserts_i (.*);
`default_nettype wire

// ===== verif/cscl_exec_model.sv
`default_nettype none
module cscl_exec_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [2:0] n_call,
  input wire logic [2:0] n_ret,
  input wire logic slow,
  output logic call_op = 1'b0,
  output logic ret_op = 1'b0,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] k = 4'h0;
  logic g = 1'b0;
  // ====================
  // all calls first, then returns; slow mode issues every other cycle
  always @(posedge clk)
  begin
    g <= ~g;
    call_op <= 1'b0;
    ret_op <= 1'b0;
    if (start)
      k <= {1'b0, n_call} + {1'b0, n_ret};
    else if (k != 4'h0 && (!slow || g))
    begin
      call_op <= k > {1'b0, n_ret};
      ret_op <= k <= {1'b0, n_ret};
      k <= k - 4'h1;
    end
  end
  assign busy = k != 4'h0;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, carry_wr = 0;
  logic carry_out = 0, irq_take = 0, cur_irq_enable = 0, save_kind = 0;
  logic restore_op = 0, restore_expect = 0, start = 0, slow = 0, rd_d = 0;
  logic tr_seen = 0, call_op, ret_op, busy, carry_in, reg_err, access_ok;
  logic depth_trap, prot_trap, context_trap, irq_dispatch, prev_irq_enable;
  logic periph_req = 0, sysreg_req = 0, irq_disable_req = 0;
  logic irq_enable_req = 0;
  logic [1:0] priv_level;
  logic [2:0] n_call = 0, n_ret = 0;
  logic [4:0] flag_wr = 0, flag_val = 0;
  logic [7:0] cur_priority = 0, prev_priority;
  logic [15:0] reg_addr = 0;
  logic [19:0] save_ptr = 0, prev_ptr;
  logic [31:0] reg_wdata = 0, reg_rdata, v, q[$];
  logic [31:0] t[6] = '{32'hbfbbf821, 32'hb78bf820, 32'hbffbff20,
    32'hbbebbf20, 32'hbc1bc004, 32'hbf8bf86c};
  int error_cnt = 0, checked = 0, cyc = 0, i;
  localparam logic [15:0] sa = cscl_pkg::status_word_addr;
  localparam logic [15:0] la = cscl_pkg::link_offset_addr;
  cscl_core_state cscl_core_state_i (.*);
  cscl_exec_model cscl_exec_model_i (.*);
  initial forever #25 clk = ~clk;
  // ====================
  // tasks
  task complete_run;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // access granted for request n%4 (periph, sysreg, disable, enable)
  // at level n/4
  function automatic logic ok_exp(input int n);
    return n / 4 == 2 || (n / 4 == 1 && n % 2 == 0);
  endfunction
  task wr(input logic [15:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // table entry: start status, expected status, calls, returns, trap
  task run(input logic [31:0] e);
    wr(sa, {20'h0, e[31:20]});
    start <= 1'b1;
    {n_call, n_ret} <= e[7:2];
    slow <= 1'($urandom);
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy)
      @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  // ====================
  // watcher and cycle limit
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    tr_seen <= !start && (tr_seen || depth_trap);
    if (++cyc > 2000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  always @(negedge clk)
    if (rd_d)
      cmp(reg_rdata, q.pop_front());
  // ====================
  // main sequence
  initial
  begin
    void'($urandom(32'hf075c69b));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(sa, cscl_pkg::status_reset);
    wr(la, '1);
    rd(la, cscl_pkg::link_wmask);
    v = $urandom & cscl_pkg::status_wmask;
    wr(sa, v);
    rd(sa, v);
    for (i = 0; i < 6; i++)
    begin
      run(t[i]);
      rd(sa, {20'h0, t[i][19:8]});
      cmp({31'h0, tr_seen}, {31'h0, t[i][0]});
    end
    for (i = 0; i < 16; i++)
    begin
      if (i % 4 == 0)
        wr(sa, {20'h0, 2'(i / 4), 10'h380});
      {periph_req, sysreg_req, irq_disable_req, irq_enable_req} <=
        4'h8 >> (i % 4);
      @(posedge clk);
      {periph_req, sysreg_req, irq_disable_req, irq_enable_req} <= 4'h0;
      @(negedge clk);
      cmp({30'h0, access_ok, prot_trap}, {30'h0, ok_exp(i), !ok_exp(i)});
      @(posedge clk);
    end
    repeat (4)
    begin
      v = $urandom;
      {cur_priority, cur_irq_enable, save_kind, save_ptr} <=
        {v[31:22], v[19:0]};
      irq_take <= 1'b1;
      @(posedge clk);
      irq_take <= 1'b0;
      restore_op <= 1'b1;
      restore_expect <= v[21];
      @(posedge clk);
      restore_op <= 1'b0;
      @(negedge clk) cmp({31'h0, context_trap}, {31'h0, v[21] ^ v[22]});
      @(posedge clk);
      rd(la, {v[31:22], 2'h0, v[19:0]});
    end
    v = $urandom;
    {flag_wr, flag_val, carry_wr, carry_out} <= {5'h0f, v[4:0], 1'b1, v[5]};
    @(posedge clk);
    {flag_wr, carry_wr} <= 6'h0;
    // low bits still hold the last privilege write (level 11)
    rd(sa, {v[5], v[3:0], 15'h0, 12'hf80});
    rd(16'hfe08, 32'h0000_0000);
    @(negedge clk);
    cmp({31'h0, reg_err}, 32'h0000_0001);
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule
`default_nettype wire
